// [verilog/aux_meas_pkg.sv]
// Constants for the auxiliary converter, temperature sensor and battery monitor.
// Assumes a 25 MHz mclk and 7-bit register addresses on the serial register port.
`default_nettype none

package aux_meas_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] CONV_SETUP_ADDR  = 7'h0F;
    localparam logic [6:0] SUPPLY_OFFS_ADDR = 7'h10;
    localparam logic [6:0] RESULT_ADDR      = 7'h11;
    localparam logic [6:0] TS_CTRL_ADDR     = 7'h12;
    localparam logic [6:0] TV_OFFS_ADDR     = 7'h13;
    localparam logic [6:0] BAT_THR_ADDR     = 7'h1A;
    localparam logic [6:0] BAT_LEVEL_ADDR   = 7'h1B;
    localparam int BUSY_BIT     = 7;
    localparam int SEL_MSB      = 6;
    localparam int SEL_LSB      = 4;
    localparam int REF_MSB      = 3;
    localparam int REF_LSB      = 2;
    localparam int GAIN_MSB     = 1;
    localparam int GAIN_LSB     = 0;
    localparam int SOFFS_MSB    = 3;
    localparam int SPAN_MSB     = 7;
    localparam int SPAN_LSB     = 6;
    localparam int SHIFT_EN_BIT = 5;
    localparam int TRIM_EN_BIT  = 4;
    localparam int TSTRIM_MSB   = 3;
    localparam int TSTRIM_LSB   = 2;
    localparam int VBGTRIM_MSB  = 1;
    localparam int LEVEL_W      = 5;
    localparam logic [7:0] SETUP_RST  = 8'h00;
    localparam logic [3:0] SOFFS_RST  = 4'h0;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] TSCTRL_RST = 8'h20;
    localparam logic [7:0] TVOFFS_RST = 8'h00;
    localparam logic [4:0] THR_RST    = 5'h14;
    localparam logic [2:0] TEMP_INPUT  = 3'h0;
    localparam logic [1:0] BANDGAP_REF = 2'h0;
    localparam logic [2:0] LOW_RUN     = 3'h4;
    localparam logic [3:0] BYTE_LAST   = 4'h7;
    localparam logic [3:0] WORD_LAST   = 4'hF;
    localparam logic [3:0] DATA_FIRST  = 4'h8;
    localparam int CLK_PERIOD_NS  = 40;
    localparam int CONV_TIME_NS   = 350_000;
    localparam int MEAS_TIME_NS   = 250_000;
    localparam int PERIOD_TIME_NS = 1_000_000_000;
    localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEAS_CYCLES    = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERIOD_CYCLES  = PERIOD_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W        = 25;
endpackage

`default_nettype wire

// [verilog/interval_timer.sv]
// One-shot cycle counter: done pulses in the len-th cycle after start.
// Assumes len is at least one; stop abandons a running count.
`default_nettype none

module interval_timer #(
    parameter int W = 25
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // control
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] len,
    // status
    output logic              done,
    output logic              running
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
    } tmr_t;

    tmr_t tmr_reg;
    tmr_t tmr_next;

    assign done    = tmr_reg.run && (tmr_reg.cnt == W'(1));
    assign running = tmr_reg.run;

    always_comb begin
        tmr_next = tmr_reg;
        if (start) begin
            tmr_next.cnt = len;
            tmr_next.run = 1'b1;
        end else if (stop || done) begin
            tmr_next.run = 1'b0;
        end else if (tmr_reg.run) begin
            tmr_next.cnt = tmr_reg.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end
endmodule

`default_nettype wire

// [verilog/reg_serial_port.sv]
// Serial register port: R/W bit, 7-bit address, then data bytes, MSB first.
// Assumes sck idles low; data in on rising edge, out on falling edge.
`default_nettype none

module reg_serial_port (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // pins
    input  wire logic       spi_sel_n,
    input  wire logic       spi_sck,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    output logic            spi_sdo_oe,
    // register side
    output logic            wr_en,
    output logic [6:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [6:0]      rd_addr,
    input  wire logic [7:0] rd_data
);
    typedef struct packed {
        logic [2:0] sel_s;
        logic [2:0] sck_s;
        logic [2:0] sdi_s;
        logic       sel_f;
        logic       sck_f;
        logic       sdi_f;
        logic [3:0] bitcnt;
        logic       rw;
        logic [6:0] addr;
        logic [7:0] shin;
        logic [7:0] shout;
        logic       sdo;
        logic       inc_pend;
        logic       load_pend;
        logic       wr;
        logic [7:0] wdata;
    } sp_t;

    sp_t sp_reg;
    sp_t sp_next;
    logic sck_new;
    logic sdi_new;
    logic [7:0] byte_in;

    assign spi_sdo    = sp_reg.sdo;
    assign spi_sdo_oe = !sp_reg.sel_f;
    assign wr_en      = sp_reg.wr;
    assign wr_addr    = sp_reg.addr;
    assign wr_data    = sp_reg.wdata;
    assign rd_addr    = sp_reg.addr;

    always_comb begin
        sp_next       = sp_reg;
        sp_next.wr    = 1'b0;
        sp_next.sel_s = {sp_reg.sel_s[1:0], spi_sel_n};
        sp_next.sck_s = {sp_reg.sck_s[1:0], spi_sck};
        sp_next.sdi_s = {sp_reg.sdi_s[1:0], spi_sdi};
        // a level counts once the second and third stages agree
        if (sp_reg.sel_s[1] == sp_reg.sel_s[2]) begin
            sp_next.sel_f = sp_reg.sel_s[2];
        end
        sck_new = (sp_reg.sck_s[1] == sp_reg.sck_s[2]) ? sp_reg.sck_s[2] : sp_reg.sck_f;
        sdi_new = (sp_reg.sdi_s[1] == sp_reg.sdi_s[2]) ? sp_reg.sdi_s[2] : sp_reg.sdi_f;
        sp_next.sck_f = sck_new;
        sp_next.sdi_f = sdi_new;
        byte_in = {sp_reg.shin[6:0], sdi_new};
        if (sp_reg.inc_pend) begin
            sp_next.inc_pend  = 1'b0;
            sp_next.addr      = sp_reg.addr + 7'h01;
            sp_next.load_pend = !sp_reg.rw;
        end else if (sp_reg.load_pend) begin
            sp_next.load_pend = 1'b0;
            sp_next.shout     = rd_data;
        end
        if (sp_reg.sel_f) begin
            sp_next.bitcnt = '0;
        end else if (sck_new && !sp_reg.sck_f) begin
            sp_next.shin   = byte_in;
            sp_next.bitcnt = sp_reg.bitcnt + 4'h1;
            if (sp_reg.bitcnt == aux_meas_pkg::BYTE_LAST) begin
                sp_next.rw        = byte_in[7];
                sp_next.addr      = byte_in[6:0];
                sp_next.load_pend = !byte_in[7];
            end else if (sp_reg.bitcnt == aux_meas_pkg::WORD_LAST) begin
                // burst: the next byte goes to the following address
                sp_next.bitcnt   = aux_meas_pkg::DATA_FIRST;
                sp_next.wr       = sp_reg.rw;
                sp_next.wdata    = byte_in;
                sp_next.inc_pend = 1'b1;
            end
        end else if (!sck_new && sp_reg.sck_f) begin
            sp_next.sdo   = sp_reg.shout[7];
            sp_next.shout = {sp_reg.shout[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sp_reg       <= '0;
            sp_reg.sel_s <= 3'h7;
            sp_reg.sel_f <= 1'b1;
        end else begin
            sp_reg <= sp_next;
        end
    end
endmodule

`default_nettype wire

// [verilog/aux_sensor_adc_battery_monitor.sv]
// Auxiliary measurement control: 8-bit converter, temperature sensor, battery monitor.
// Assumes converter and battery samples are settled values on mclk at window end.
`default_nettype none

module aux_sensor_adc_battery_monitor #(
    parameter logic [24:0] CONV_CYCLES   = 25'(aux_meas_pkg::CONV_CYCLES),
    parameter logic [24:0] MEAS_CYCLES   = 25'(aux_meas_pkg::MEAS_CYCLES),
    parameter logic [24:0] PERIOD_CYCLES = 25'(aux_meas_pkg::PERIOD_CYCLES)
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // serial register port
    input  wire logic       spi_sel_n,
    input  wire logic       spi_sck,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    output logic            spi_sdo_oe,
    // control from the rest of the chip
    input  wire logic       battery_monitor_en,
    input  wire logic       battery_irq_en,
    input  wire logic       sleep_mode,
    input  wire logic       test_bus_temp_sel,
    input  wire logic       low_battery_clear,
    // analog samples
    input  wire logic [7:0] adc_sample,
    input  wire logic [4:0] battery_sample,
    // analog controls
    output logic            conv_active,
    output logic [2:0]      conv_input_sel,
    output logic [1:0]      conv_ref_sel,
    output logic [1:0]      conv_gain,
    output logic [3:0]      supply_offset,
    output logic            temp_sensor_power,
    output logic [1:0]      temp_span,
    output logic            temp_shift_en,
    output logic            trim_en,
    output logic [1:0]      trim_code,
    output logic [1:0]      bandgap_trim,
    output logic            battery_meas_power,
    output logic            rc_osc_enable,
    // interrupt
    output logic            irq_n,
    output logic            low_battery_status
);
    typedef enum logic [1:0] {BAT_OFF, BAT_MEAS, BAT_REST} bat_state_t;

    typedef struct packed {
        logic [7:0] setup;
        logic [3:0] soffs;
        logic [7:0] result;
        logic [7:0] ts_ctrl;
        logic [7:0] tvoffs;
        logic [4:0] thr;
        logic [4:0] level;
        logic [2:0] run_cnt;
        logic       low_flag;
        logic       irq_n;
        logic       ts_pwr;
        logic       rc_osc;
        bat_state_t bstate;
    } core_t;

    core_t c_reg;
    core_t c_next;

    logic       wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic       conv_start;
    logic       conv_done;
    logic       bat_start;
    logic       bat_stop;
    logic       bat_done;
    logic [24:0] bat_len;
    logic       below;
    logic       busy;

    // ****************************************
    // serial port and timers
    // ****************************************
    reg_serial_port u_port (
        .mclk       (mclk),
        .resetn     (resetn),
        .spi_sel_n  (spi_sel_n),
        .spi_sck    (spi_sck),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .wr_en      (wr_en),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .rd_addr    (rd_addr),
        .rd_data    (rd_data)
    );

    interval_timer #(.W(aux_meas_pkg::TIMER_W)) u_conv_tmr (
        .mclk    (mclk),
        .resetn  (resetn),
        .start   (conv_start),
        .stop    (1'b0),
        .len     (CONV_CYCLES),
        .done    (conv_done),
        .running ()
    );

    interval_timer #(.W(aux_meas_pkg::TIMER_W)) u_bat_tmr (
        .mclk    (mclk),
        .resetn  (resetn),
        .start   (bat_start),
        .stop    (bat_stop),
        .len     (bat_len),
        .done    (bat_done),
        .running ()
    );

    // ****************************************
    // outputs
    // ****************************************
    assign busy               = c_reg.setup[aux_meas_pkg::BUSY_BIT];
    assign conv_active        = busy;
    assign conv_input_sel     = c_reg.setup[aux_meas_pkg::SEL_MSB:aux_meas_pkg::SEL_LSB];
    assign conv_ref_sel       = c_reg.setup[aux_meas_pkg::REF_MSB:aux_meas_pkg::REF_LSB];
    assign conv_gain          = c_reg.setup[aux_meas_pkg::GAIN_MSB:aux_meas_pkg::GAIN_LSB];
    assign supply_offset      = c_reg.soffs;
    assign temp_sensor_power  = c_reg.ts_pwr;
    assign temp_span          = c_reg.ts_ctrl[aux_meas_pkg::SPAN_MSB:aux_meas_pkg::SPAN_LSB];
    assign temp_shift_en      = c_reg.ts_ctrl[aux_meas_pkg::SHIFT_EN_BIT];
    assign trim_en            = c_reg.ts_ctrl[aux_meas_pkg::TRIM_EN_BIT];
    assign trim_code          = c_reg.ts_ctrl[aux_meas_pkg::TSTRIM_MSB:aux_meas_pkg::TSTRIM_LSB];
    assign bandgap_trim       = c_reg.ts_ctrl[aux_meas_pkg::VBGTRIM_MSB:0];
    assign battery_meas_power = (c_reg.bstate == BAT_MEAS);
    assign rc_osc_enable      = c_reg.rc_osc;
    assign irq_n              = c_reg.irq_n;
    assign low_battery_status = c_reg.low_flag;

    // a start arriving as the previous conversion ends is kept
    assign conv_start = wr_en && (wr_addr == aux_meas_pkg::CONV_SETUP_ADDR)
                        && wr_data[aux_meas_pkg::BUSY_BIT] && (!busy || conv_done);
    assign below      = (battery_sample < c_reg.thr);

    // ****************************************
    // register reads
    // ****************************************
    always_comb begin
        unique case (rd_addr)
            aux_meas_pkg::CONV_SETUP_ADDR:  rd_data = c_reg.setup;
            aux_meas_pkg::SUPPLY_OFFS_ADDR: rd_data = {4'h0, c_reg.soffs};
            aux_meas_pkg::RESULT_ADDR:      rd_data = c_reg.result;
            aux_meas_pkg::TS_CTRL_ADDR:     rd_data = c_reg.ts_ctrl;
            aux_meas_pkg::TV_OFFS_ADDR:     rd_data = c_reg.tvoffs;
            aux_meas_pkg::BAT_THR_ADDR:     rd_data = {3'h0, c_reg.thr};
            aux_meas_pkg::BAT_LEVEL_ADDR:   rd_data = {3'h0, c_reg.level};
            default:                        rd_data = 8'h00;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        c_next    = c_reg;
        bat_start = 1'b0;
        bat_stop  = 1'b0;
        bat_len   = MEAS_CYCLES;
        if (wr_en) begin
            unique case (wr_addr)
                aux_meas_pkg::CONV_SETUP_ADDR: begin
                    c_next.setup[aux_meas_pkg::SEL_MSB:0] = wr_data[aux_meas_pkg::SEL_MSB:0];
                end
                aux_meas_pkg::SUPPLY_OFFS_ADDR: c_next.soffs   = wr_data[aux_meas_pkg::SOFFS_MSB:0];
                aux_meas_pkg::TS_CTRL_ADDR:     c_next.ts_ctrl = wr_data;
                aux_meas_pkg::TV_OFFS_ADDR:     c_next.tvoffs  = wr_data;
                aux_meas_pkg::BAT_THR_ADDR:     c_next.thr     = wr_data[aux_meas_pkg::LEVEL_W-1:0];
                default: ;
            endcase
        end
        if (conv_start) begin
            c_next.setup[aux_meas_pkg::BUSY_BIT] = 1'b1;
        end else if (conv_done) begin
            c_next.setup[aux_meas_pkg::BUSY_BIT] = 1'b0;
        end
        if (conv_done) begin
            c_next.result = adc_sample + (temp_shift_en ? c_reg.tvoffs : 8'h00);
        end
        c_next.ts_pwr = (c_next.setup[aux_meas_pkg::SEL_MSB:aux_meas_pkg::SEL_LSB] == aux_meas_pkg::TEMP_INPUT)
                        || test_bus_temp_sel;
        c_next.rc_osc = battery_monitor_en && sleep_mode;
        unique case (c_reg.bstate)
            BAT_OFF: begin
                c_next.run_cnt = 3'h0;
                if (battery_monitor_en) begin
                    bat_start     = 1'b1;
                    c_next.bstate = BAT_MEAS;
                end
            end
            BAT_MEAS: begin
                if (!battery_monitor_en) begin
                    bat_stop      = 1'b1;
                    c_next.bstate = BAT_OFF;
                end else if (bat_done) begin
                    c_next.level = battery_sample;
                    if (below) begin
                        if (c_reg.run_cnt != aux_meas_pkg::LOW_RUN) begin
                            c_next.run_cnt = c_reg.run_cnt + 3'h1;
                        end
                    end else begin
                        c_next.run_cnt = 3'h0;
                    end
                    bat_start     = 1'b1;
                    bat_len       = PERIOD_CYCLES - MEAS_CYCLES;
                    c_next.bstate = BAT_REST;
                end
            end
            BAT_REST: begin
                if (!battery_monitor_en) begin
                    bat_stop      = 1'b1;
                    c_next.bstate = BAT_OFF;
                end else if (bat_done) begin
                    bat_start     = 1'b1;
                    c_next.bstate = BAT_MEAS;
                end
            end
        endcase
        // set wins over a clear in the same cycle
        if (bat_done && (c_reg.bstate == BAT_MEAS) && battery_monitor_en && below
            && (c_next.run_cnt == aux_meas_pkg::LOW_RUN)) begin
            c_next.low_flag = 1'b1;
        end else if (low_battery_clear) begin
            c_next.low_flag = 1'b0;
        end
        c_next.irq_n = !(c_next.low_flag && battery_irq_en);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            c_reg          <= '0;
            c_reg.setup    <= aux_meas_pkg::SETUP_RST;
            c_reg.soffs    <= aux_meas_pkg::SOFFS_RST;
            c_reg.result   <= aux_meas_pkg::RESULT_RST;
            c_reg.ts_ctrl  <= aux_meas_pkg::TSCTRL_RST;
            c_reg.tvoffs   <= aux_meas_pkg::TVOFFS_RST;
            c_reg.thr      <= aux_meas_pkg::THR_RST;
            c_reg.irq_n    <= 1'b1;
            c_reg.ts_pwr   <= 1'b1;
            c_reg.bstate   <= BAT_OFF;
        end else begin
            c_reg <= c_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [24:0] conv_age;

    always_ff @(posedge mclk) begin
        if (!resetn || conv_start) begin
            conv_age <= 25'h0000000;
        end else if (busy) begin
            conv_age <= conv_age + 25'h0000001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_busy_clear_time: assert property (
        $fell(busy) |-> (conv_age == CONV_CYCLES)
    ) else $error("busy flag cleared at the wrong time");

    a_reset_input_ref: assert property (
        !$past(resetn) |-> (conv_input_sel == aux_meas_pkg::TEMP_INPUT)
                           && (conv_ref_sel == aux_meas_pkg::BANDGAP_REF) && temp_shift_en
    ) else $error("reset did not select sensor and bandgap");

    a_select_write: assert property (
        wr_en && (wr_addr == aux_meas_pkg::CONV_SETUP_ADDR)
        |=> (conv_input_sel == $past(wr_data[aux_meas_pkg::SEL_MSB:aux_meas_pkg::SEL_LSB]))
            && (conv_ref_sel == $past(wr_data[aux_meas_pkg::REF_MSB:aux_meas_pkg::REF_LSB]))
    ) else $error("input or reference select not taken");

    a_gain_write: assert property (
        wr_en && (wr_addr == aux_meas_pkg::CONV_SETUP_ADDR)
        |=> conv_gain == $past(wr_data[aux_meas_pkg::GAIN_MSB:aux_meas_pkg::GAIN_LSB])
    ) else $error("gain field not taken");

    a_result_offset: assert property (
        conv_done |=> c_reg.result == $past(adc_sample) + ($past(temp_shift_en) ? $past(c_reg.tvoffs) : 8'h00)
    ) else $error("result offset wrong");

    a_monitor_off: assert property (
        !battery_monitor_en |=> !battery_meas_power
    ) else $error("monitor powered while disabled");

    a_meas_window: assert property (
        $rose(battery_meas_power) |-> battery_meas_power [*8]
    ) else $error("measurement window too short");

    a_rc_osc_sleep: assert property (
        battery_monitor_en && sleep_mode |=> rc_osc_enable
    ) else $error("rc oscillator not enabled in sleep");

    a_level_upper: assert property (
        (rd_addr == aux_meas_pkg::BAT_LEVEL_ADDR) |-> (rd_data[7:5] == 3'h0)
    ) else $error("level upper bits not zero");

    a_irq_gated: assert property (
        !battery_irq_en |=> irq_n
    ) else $error("interrupt raised while disabled");

    a_irq_four_runs: assert property (
        $fell(irq_n) |-> (c_reg.run_cnt == aux_meas_pkg::LOW_RUN)
    ) else $error("interrupt before four low readings");

    a_run_restart: assert property (
        bat_done && (c_reg.bstate == BAT_MEAS) && battery_monitor_en && !below |=> (c_reg.run_cnt == 3'h0)
    ) else $error("run count not restarted");

    c_conv_done: cover property (conv_done);
    c_irq_low: cover property ($fell(irq_n));
    c_level_taken: cover property (bat_done && (c_reg.bstate == BAT_MEAS));
    c_restart_busy: cover property (conv_start && busy);
endmodule

`default_nettype wire

// [tb/reg_host.sv]
// Microcontroller model on the serial register port: one frame per call.
// Assumes sck low for 9 mclk and high for 8, above the 4-cycle minimum of the port.
`default_nettype none
// ****
// host model
// ****
module reg_host (
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      sel_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {wr, a, wd};
        rd = 8'h00;
        @(posedge mclk) sel_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge mclk) sdi <= sh[i];
            repeat (8) @(posedge mclk);
            if (i < 8) rd[i] = sdo;
            sck <= 1'b1;
            repeat (8) @(posedge mclk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        sel_n <= 1'b1;
        // released line shows the inverse, not a stale value
        sdi <= ~sdi;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// [tb/aux_sensor_adc_battery_monitor_tb.sv]
// Testbench: register port, converter, temperature controls and battery monitor.
// Assumes short counts CONV 20, MEAS 10, PERIOD 40 cycles.
`default_nettype none
// ****
// bench top
// ****
module aux_sensor_adc_battery_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, resetn = 0, spi_sel_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, battery_monitor_en = 0;
    logic battery_irq_en = 0, sleep_mode = 0, test_bus_temp_sel = 0, low_battery_clear = 0, conv_active;
    logic [7:0] adc_sample = 8'h30, d;
    logic [4:0] battery_sample = 5'h10;
    logic [2:0] conv_input_sel;
    logic [1:0] conv_ref_sel, conv_gain, temp_span, trim_code, bandgap_trim;
    logic [3:0] supply_offset;
    logic temp_sensor_power, temp_shift_en, trim_en, battery_meas_power, rc_osc_enable, irq_n, low_battery_status;
    int err_count = 0, checked = 0, n;
    always #20 mclk = ~mclk;
    reg_host host_u (.mclk, .sel_n(spi_sel_n), .sck(spi_sck), .sdi(spi_sdi), .sdo(spi_sdo));
    aux_sensor_adc_battery_monitor #(.CONV_CYCLES(25'd20), .MEAS_CYCLES(25'd10), .PERIOD_CYCLES(25'd40)) dut_u (
        .mclk, .resetn, .spi_sel_n, .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe, .battery_monitor_en,
        .battery_irq_en, .sleep_mode, .test_bus_temp_sel, .low_battery_clear, .adc_sample, .battery_sample,
        .conv_active, .conv_input_sel, .conv_ref_sel, .conv_gain, .supply_offset, .temp_sensor_power,
        .temp_span, .temp_shift_en, .trim_en, .trim_code, .bandgap_trim, .battery_meas_power,
        .rc_osc_enable, .irq_n, .low_battery_status);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host_u.xfer(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host_u.xfer(1'b0, a, 8'h00, d);
        chk(d, e);
    endtask
    task automatic conv(input logic [7:0] cfg, input logic [7:0] e);
        wr(aux_meas_pkg::CONV_SETUP_ADDR, cfg);
        chk(conv_active, 1'b1);
        for (int i = 0; i < 100 && conv_active !== 1'b0; i++) @(negedge mclk);
        rd(aux_meas_pkg::CONV_SETUP_ADDR, {1'b0, cfg[6:0]});
        rd(aux_meas_pkg::RESULT_ADDR, e);
    endtask
    task automatic t_reset;
        rd(aux_meas_pkg::CONV_SETUP_ADDR, 8'h00);
        rd(aux_meas_pkg::TS_CTRL_ADDR, 8'h20);
        rd(aux_meas_pkg::BAT_THR_ADDR, 8'h14);
        chk({conv_input_sel, conv_ref_sel, temp_sensor_power, spi_sdo_oe}, 8'h02);
        $display("reset test done");
    endtask
    task automatic t_conv;
        wr(aux_meas_pkg::TV_OFFS_ADDR, 8'h05);
        wr(aux_meas_pkg::SUPPLY_OFFS_ADDR, 8'h07);
        chk(supply_offset, 8'h07);
        conv(8'h8B, 8'h35);
        chk({conv_ref_sel, conv_gain}, 8'h0B);
        wr(aux_meas_pkg::TS_CTRL_ADDR, 8'h5D);
        chk({temp_span, temp_shift_en, trim_en, trim_code, bandgap_trim}, 8'h5D);
        conv(8'h80, 8'h30);
        wr(aux_meas_pkg::CONV_SETUP_ADDR, 8'h10);
        chk({conv_input_sel, temp_sensor_power}, 8'h02);
        @(posedge mclk) test_bus_temp_sel <= 1'b1;
        repeat (3) @(negedge mclk);
        chk(temp_sensor_power, 1'b1);
        $display("converter test done");
    endtask
    task automatic t_batt;
        logic p;
        wr(aux_meas_pkg::BAT_THR_ADDR, 8'h10);
        @(posedge mclk) battery_monitor_en <= 1'b1;
        battery_irq_en <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (220) @(negedge mclk);
        chk({rc_osc_enable, irq_n}, 8'h03);
        @(posedge mclk) battery_sample <= 5'h0F;
        n = 0;
        p = battery_meas_power;
        for (int i = 0; i < 400 && irq_n !== 1'b0; i++) begin
            @(negedge mclk);
            if (p === 1'b1 && battery_meas_power === 1'b0) n++;
            p = battery_meas_power;
        end
        chk(n[7:0], 8'h04);
        rd(aux_meas_pkg::BAT_LEVEL_ADDR, 8'h0F);
        @(posedge mclk) battery_monitor_en <= 1'b0;
        repeat (2) @(posedge mclk) low_battery_clear <= ~low_battery_clear;
        repeat (2) @(negedge mclk);
        chk({battery_meas_power, irq_n, low_battery_status}, 8'h02);
        $display("battery test done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_conv();
        t_batt();
        end_sim();
    end
endmodule
`default_nettype wire
